// [design/mrco_pkg.sv]
// Constants for the receive control output block: register map, field
// positions, mode codes and timing counts.
// Assumes a 10 MHz APB clock and a link clock sampled by that clock.
package mrco_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;

    // Control word fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 2;
    localparam int CTRL_TEN_BIT = 3;
    localparam int CTRL_LOOPBACK = 4;
    localparam int CTRL_COL_TEST = 5;
    localparam int CTRL_TERMINAL = 6;
    localparam logic [6:0] CTRL_RESET = 7'h40;

    // Status word fields
    localparam int STAT_STRAP_DV = 0;
    localparam int STAT_STRAP_ER = 1;
    localparam int STAT_STRAP_COL = 2;
    localparam int STAT_TWO_CLOCK = 3;
    localparam int STAT_FIFO_EMPTY = 4;
    localparam int STAT_FIFO_FULL = 5;
    localparam int STAT_RUNNING = 6;

    // Parallel port modes
    localparam logic [2:0] MODE_MII = 3'h0;
    localparam logic [2:0] MODE_GMII = 3'h1;
    localparam logic [2:0] MODE_RGMII = 3'h2;
    localparam logic [2:0] MODE_TBI = 3'h3;
    localparam logic [2:0] MODE_RTBI = 3'h4;

    // Code-group bit positions placed on the pins
    localparam int CG_BIT4 = 4;
    localparam int CG_BIT8 = 8;
    localparam int CG_BIT9 = 9;
    localparam int WORD_WIDTH = 10;
    localparam int FIFO_DEPTH = 8;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int PCLK_PERIOD_NS = 100;
    localparam int RX_CLK_PERIOD_NS = 800;
    localparam int RX_HALF_CYCLES = RX_CLK_PERIOD_NS / 2 / PCLK_PERIOD_NS;
    localparam logic [2:0] RX_HALF_LAST = 3'(RX_HALF_CYCLES - 1);
    localparam logic [1:0] STRAP_SETTLE_LAST = 2'h2;

    typedef enum logic [1:0] {ST_SETTLE, ST_CAPTURE, ST_RUN} mrco_state_type;

endpackage

// [design/mrco_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty reflect the true fill level.
`timescale 1ns/1ps
module mrco_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill state
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wptr_reg, wptr_next;
    logic [AW:0] rptr_reg, rptr_next;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // Pointers carry one extra wrap bit so full and empty differ
    always_comb begin
        empty = (wptr_reg == rptr_reg);
        full = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) &&
               (wptr_reg[AW] != rptr_reg[AW]);
        in_ready = !full;
        out_valid = !empty;
        push = in_valid && !full;
        pop = out_ready && !empty;
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
        out_data = mem_reg[rptr_reg[AW-1:0]];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
        end
    end

    // Storage has no reset; nothing reads a slot before it is written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wptr_reg[AW-1:0]] <= in_data;
        end
    end

endmodule

// [design/mrco_rx_ctrl.sv]
// Receive control outputs of a parallel MII-family port: valid, error and
// collision pins, with reset-time strap capture and an APB register pair.
// Assumes pins and the link clock are asynchronous to pclk.
`timescale 1ns/1ps
module mrco_rx_ctrl
    import mrco_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive word stream: {error/bit9, valid/bit8, data[7:0]}
    input wire logic word_valid,
    output logic word_ready,
    input wire logic [9:0] word_data,
    // Collision sources, asynchronous
    input wire logic collision_event,
    input wire logic transmit_active,
    // Receive clock pin
    input wire logic receive_clock_in,
    output logic receive_clock_out,
    output logic receive_clock_oe,
    // Even group clock, driven in two-clock TBI
    output logic even_group_receive_clock,
    // Receive valid pin
    input wire logic rx_valid_in,
    output logic rx_valid_out,
    output logic rx_valid_oe,
    // Receive error pin
    input wire logic rx_error_in,
    output logic rx_error_out,
    output logic rx_error_oe,
    // Collision pin
    input wire logic collision_in,
    output logic collision_out,
    output logic collision_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding used in several places
    function automatic logic is_rgmii_rtbi(input logic [2:0] m);
        return (m == MODE_RGMII) || (m == MODE_RTBI);
    endfunction

    function automatic logic is_ten_bit(input logic [2:0] m);
        return (m == MODE_TBI) || (m == MODE_RTBI);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [6:0] ctrl_reg, ctrl_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic [3:0] sync1_reg, sync2_reg;
    logic [2:0] div_cnt_reg, div_cnt_next;
    logic clk_gen_reg, clk_gen_next;
    logic link_prev_reg, link_level, link_rise, link_fall;
    mrco_state_type state_reg, state_next;
    logic [1:0] settle_reg, settle_next;
    logic [2:0] strap_reg, strap_next;
    logic [9:0] held_reg, held_next;
    logic dv_reg, dv_next, er_reg, er_next, even_reg, even_next;
    logic [2:0] mode;
    logic loopback, col_test, terminal, two_clock, running, advance;
    logic fifo_valid, fifo_ready, fifo_full, fifo_empty;
    logic [9:0] fifo_data, word_now;

    assign mode = ctrl_reg[CTRL_MODE_MSB:CTRL_MODE_LSB];
    assign loopback = ctrl_reg[CTRL_LOOPBACK];
    assign col_test = ctrl_reg[CTRL_COL_TEST];
    assign terminal = ctrl_reg[CTRL_TERMINAL];
    assign running = (state_reg == ST_RUN);
    assign two_clock = ctrl_reg[CTRL_TEN_BIT] | strap_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait, read data latched in the setup cycle
    always_comb begin
        ctrl_next = ctrl_reg;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (psel && !penable) begin
            prdata_next = 32'h0000_0000;
            pslverr_next = 1'b0;
            unique case (paddr)
                CTRL_ADDR: prdata_next = {25'h000_0000, ctrl_reg};
                STATUS_ADDR: begin
                    prdata_next[STAT_STRAP_DV] = strap_reg[0];
                    prdata_next[STAT_STRAP_ER] = strap_reg[1];
                    prdata_next[STAT_STRAP_COL] = strap_reg[2];
                    prdata_next[STAT_TWO_CLOCK] = two_clock;
                    prdata_next[STAT_FIFO_EMPTY] = fifo_empty;
                    prdata_next[STAT_FIFO_FULL] = fifo_full;
                    prdata_next[STAT_RUNNING] = running;
                end
                default: pslverr_next = 1'b1;
            endcase
        end
        // Status is read only; writes to it are dropped without error
        if (psel && penable && pwrite && paddr == CTRL_ADDR) begin
            ctrl_next = pwdata[6:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign pready = 1'b1;
    assign prdata = (psel && penable) ? prdata_reg : 32'h0000_0000;
    assign pslverr = psel && penable && pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for the link clock and the strap pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {collision_in, rx_error_in, rx_valid_in,
                          receive_clock_in};
            sync2_reg <= sync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive clock: taken from the pin in DTE, made by division in DCE
    always_comb begin
        div_cnt_next = div_cnt_reg + 3'h1;
        clk_gen_next = clk_gen_reg;
        if (div_cnt_reg == RX_HALF_LAST) begin
            div_cnt_next = 3'h0;
            clk_gen_next = !clk_gen_reg;
        end
        link_level = terminal ? sync2_reg[0] : clk_gen_reg;
        link_rise = link_level && !link_prev_reg;
        link_fall = !link_level && link_prev_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 3'h0;
            clk_gen_reg <= 1'b0;
            link_prev_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            clk_gen_reg <= clk_gen_next;
            link_prev_reg <= link_level;
        end
    end

    assign receive_clock_out = clk_gen_reg;
    assign receive_clock_oe = !terminal;

    ////////////////////////////////////////////////////////////////////////
    // Strap capture: wait for the synchronisers to fill, then sample once
    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        strap_next = strap_reg;
        unique case (state_reg)
            ST_SETTLE: begin
                settle_next = settle_reg + 2'h1;
                if (settle_reg == STRAP_SETTLE_LAST) begin
                    state_next = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                strap_next = sync2_reg[3:1];
                state_next = ST_RUN;
            end
            ST_RUN: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_SETTLE;
            settle_reg <= 2'h0;
            strap_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            strap_reg <= strap_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word buffer between the stream source and the link edges
    mrco_fifo #(
        .WIDTH(WORD_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .in_data(word_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin update. A new word is taken on each rising edge, and also on
    // falling edges in two-clock TBI where the even clock rises there.
    // An empty buffer sends an idle all-zero word rather than stalling.
    always_comb begin
        advance = running && (link_rise || (link_fall &&
                  mode == MODE_TBI && two_clock));
        fifo_ready = advance;
        word_now = fifo_valid ? fifo_data : 10'h000;
        held_next = held_reg;
        dv_next = dv_reg;
        er_next = er_reg;
        even_next = (mode == MODE_TBI) && two_clock && running &&
                    !link_level;
        if (advance) begin
            held_next = word_now;
            unique case (mode)
                MODE_RGMII: dv_next = word_now[CG_BIT8];
                MODE_RTBI: dv_next = word_now[CG_BIT4];
                MODE_TBI: begin
                    dv_next = word_now[CG_BIT8];
                    er_next = word_now[CG_BIT9];
                end
                default: begin
                    dv_next = word_now[CG_BIT8];
                    er_next = word_now[CG_BIT9];
                end
            endcase
        end else if (running && link_fall) begin
            // Second half of a double-rate clock cycle
            if (mode == MODE_RGMII) begin
                dv_next = held_reg[CG_BIT8] ^ held_reg[CG_BIT9];
            end else if (mode == MODE_RTBI) begin
                dv_next = held_reg[CG_BIT9];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_reg <= 10'h000;
            dv_reg <= 1'b0;
            er_reg <= 1'b0;
            even_reg <= 1'b0;
        end else begin
            held_reg <= held_next;
            dv_reg <= dv_next;
            er_reg <= er_next;
            even_reg <= even_next;
        end
    end

    // Enables stay low until the straps have been taken
    assign rx_valid_out = dv_reg;
    assign rx_valid_oe = running;
    assign rx_error_out = er_reg;
    assign rx_error_oe = running && !is_rgmii_rtbi(mode);
    assign even_group_receive_clock = even_reg;

    ////////////////////////////////////////////////////////////////////////
    // Collision is a pure gate path: it must not wait for any clock.
    // The far side is trusted to ignore it in full duplex.
    always_comb begin
        if (col_test) begin
            collision_out = transmit_active;
        end else if (loopback) begin
            collision_out = 1'b0;
        end else begin
            collision_out = collision_event;
        end
    end
    assign collision_oe = running && !is_ten_bit(mode);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rise_rgmii;
        running && link_rise && mode == MODE_RGMII;
    endsequence
    sequence s_fall_rgmii;
        running && link_fall && mode == MODE_RGMII;
    endsequence

    property p_strap_quiet;
        !running |-> !rx_valid_oe && !rx_error_oe && !collision_oe;
    endproperty
    a_strap_quiet: assert property (p_strap_quiet)
        else $error("pins driven before straps taken");

    property p_mii_rise;
        running && link_rise && (mode == MODE_MII || mode == MODE_GMII)
        |=> rx_valid_out == $past(word_now[CG_BIT8]) &&
            rx_error_out == $past(word_now[CG_BIT9]);
    endproperty
    a_mii_rise: assert property (p_mii_rise)
        else $error("MII valid or error not updated on rising edge");

    property p_mii_hold;
        (mode == MODE_MII || mode == MODE_GMII) && !link_rise
        && $stable(mode) |=> $stable(rx_valid_out);
    endproperty
    a_mii_hold: assert property (p_mii_hold)
        else $error("MII valid changed without rising edge");

    // The falling half follows the rising half within one link period
    property p_rgmii_ddr;
        s_rise_rgmii ##[2:8] s_fall_rgmii |=> rx_valid_out ==
        ($past(held_reg[CG_BIT8]) ^ $past(held_reg[CG_BIT9]));
    endproperty
    a_rgmii_ddr: assert property (p_rgmii_ddr)
        else $error("RGMII falling edge control value wrong");

    // Valid strap seen at the capture edge must reach the clock choice
    property p_two_clock;
        $rose(running) |-> two_clock ==
            (ctrl_reg[CTRL_TEN_BIT] | $past(sync2_reg[1]));
    endproperty
    a_two_clock: assert property (p_two_clock)
        else $error("TBI clock scheme selection wrong");

    property p_tbi_fall;
        running && link_fall && mode == MODE_TBI && two_clock
        |=> rx_valid_out == $past(word_now[CG_BIT8]) &&
            rx_error_out == $past(word_now[CG_BIT9]);
    endproperty
    a_tbi_fall: assert property (p_tbi_fall)
        else $error("TBI even group bits not placed");

    property p_rtbi_fall;
        running && link_fall && mode == MODE_RTBI
        |=> rx_valid_out == $past(held_reg[CG_BIT9]);
    endproperty
    a_rtbi_fall: assert property (p_rtbi_fall)
        else $error("RTBI falling edge bit 9 missing");

    property p_er_hiz;
        is_rgmii_rtbi(mode) |-> !rx_error_oe;
    endproperty
    a_er_hiz: assert property (p_er_hiz)
        else $error("error pin driven in RGMII or RTBI");

    property p_col_follow;
        !loopback && !col_test |-> collision_out == collision_event;
    endproperty
    a_col_follow: assert property (p_col_follow)
        else $error("collision pin does not follow collision");

    property p_col_loop;
        loopback && !col_test |-> !collision_out;
    endproperty
    a_col_loop: assert property (p_col_loop)
        else $error("collision not held low in loopback");

    property p_col_hiz;
        is_ten_bit(mode) |-> !collision_oe;
    endproperty
    a_col_hiz: assert property (p_col_hiz)
        else $error("collision pin driven in ten bit mode");

    property p_dce_clock;
        !terminal && $stable(terminal) [*5] |-> receive_clock_oe
        && (clk_gen_reg != $past(clk_gen_reg, 4));
    endproperty
    a_dce_clock: assert property (p_dce_clock)
        else $error("DCE receive clock not driven at 800 ns");

endmodule

// [sim/mrco_mac_model.sv]
// Far-side MAC model: straps the pins in reset, supplies the link clock.
// Assumes the bench resolves each pin from both parties' enables.
`timescale 1ns/1ps
module mrco_mac_model (
    // Bench controls
    input wire logic run,
    input wire logic strap_en,
    input wire logic [2:0] straps,
    // Pins driven from the MAC side
    output logic rclk,
    output logic strap_oe,
    output logic [2:0] strap_val
);
    ////////////////////////////////////////////////////////////
    // Link clock; odd offset keeps it off the pclk edges
    initial begin
        rclk = 1'b0;
        #13;
        forever begin
            #400;
            if (run) rclk = ~rclk; // Stands still between frames
        end
    end
    // Strap levels only while asked, released one cycle after running starts
    assign strap_oe = strap_en;
    assign strap_val = straps;
    // Collision pin is never read: the MAC runs full duplex
endmodule

// [sim/mrco_rx_ctrl_tb.sv]
// Bench for the receive control outputs: APB master, stream source,
// pin resolution and scenario tasks.
// Assumes mrco_pkg and the MAC model are compiled first.
`timescale 1ns/1ps
module mrco_rx_ctrl_tb
    import mrco_pkg::*;
;
    // Bus, stream and pin signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic word_valid, word_ready, collision_event, transmit_active;
    logic [9:0] word_data;
    logic rclk_oe, rclk_out, rclk_m, rclk_w, dv_out, dv_oe, dv_w;
    logic er_out, er_oe, er_w, col_out, col_oe, col_w, rerr, flip;
    logic run, strap_en, strap_oe, even_clk;
    logic [2:0] straps, strap_val;
    int n_fail, total_checks;

    mrco_rx_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data),
        .collision_event(collision_event),
        .transmit_active(transmit_active), .receive_clock_in(rclk_w),
        .receive_clock_out(rclk_out), .receive_clock_oe(rclk_oe),
        .even_group_receive_clock(even_clk), .rx_valid_in(dv_w),
        .rx_valid_out(dv_out), .rx_valid_oe(dv_oe), .rx_error_in(er_w),
        .rx_error_out(er_out), .rx_error_oe(er_oe),
        .collision_in(col_w), .collision_out(col_out),
        .collision_oe(col_oe));
    mrco_mac_model mac_u (.run(run), .strap_en(strap_en),
        .straps(straps), .rclk(rclk_m), .strap_oe(strap_oe),
        .strap_val(strap_val));

    // Undriven pins toggle, so a stale level can never look right
    assign rclk_w = rclk_oe ? rclk_out : rclk_m;
    assign dv_w = dv_oe ? dv_out : (strap_oe ? strap_val[0] : flip);
    assign er_w = er_oe ? er_out : (strap_oe ? strap_val[1] : flip);
    assign col_w = col_oe ? col_out : (strap_oe ? strap_val[2] : flip);
    always @(posedge pclk) flip <= ~flip;
    // Clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////
    // Common tasks
    task chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task final_report;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; reply is taken with pready, then released
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Reply is taken at the rising edge that sees pready high
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rdat = prdata;
                rerr = pslverr;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i == 20) begin
            chk(1'b0, "apb hang");
            final_report;
        end
    endtask
    task ctl(input logic [31:0] v);
        apb(1'b1, CTRL_ADDR, v);
        cyc(12); // Lets zero words flush the pins
    endtask
    task push(input logic [9:0] w);
        int i;
        word_data <= w;
        word_valid <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(negedge pclk);
            if (word_ready === 1'b1) break;
        end
        @(posedge pclk);
        word_valid <= 1'b0;
        @(posedge pclk);
        if (i == 200) begin
            chk(1'b0, "push hang");
            final_report;
        end
    endtask
    // Word out: valid rises in link phase lvl, next phase shows nxt
    task seq(input logic [9:0] w, input logic lvl, input logic nxt,
        input logic er);
        int i;
        push(w);
        for (i = 0; i < 40; i++) begin
            @(negedge pclk);
            if (dv_out === 1'b1) break;
        end
        if (i == 40) begin
            chk(1'b0, "valid hang");
            final_report;
        end
        chk(rclk_w === lvl, "valid phase");
        chk(er_oe !== 1'b1 || er_out === er, "error value");
        repeat (5) @(negedge pclk);
        chk(dv_out === nxt, "valid next phase");
        @(posedge pclk);
    endtask
    task do_reset(input logic [2:0] s);
        presetn <= 1'b0;
        straps <= s;
        strap_en <= 1'b1;
        cyc(8);
        presetn <= 1'b1;
        cyc(2);
        chk(dv_oe === 1'b0 && er_oe === 1'b0 && col_oe === 1'b0, "oe");
        cyc(3);
        strap_en <= 1'b0;
        cyc(4);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rdat[2:0] === s && rdat[STAT_RUNNING] === 1'b1, "straps");
    endtask
    // Scenarios
    task t_apb;
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rdat === 32'h0000_0040 && rerr === 1'b0, "ctrl reset");
        apb(1'b1, CTRL_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rdat === 32'h0000_007F, "ctrl width");
        apb(1'b1, 8'h08, 32'h0000_0001);
        chk(rerr === 1'b1, "unmapped write");
        apb(1'b0, 8'h08, 32'h0);
        chk(rerr === 1'b1 && rdat === 32'h0, "unmapped read");
    endtask
    task t_mii;
        ctl(32'h0000_0040);
        chk(dv_oe === 1'b1 && er_oe === 1'b1, "mii oe");
        seq(10'h100, 1'b1, 1'b1, 1'b0);
        collision_event <= 1'b1;
        cyc(2);
        chk(col_oe === 1'b1 && col_out === 1'b1, "col");
        ctl(32'h0000_0041);
        seq(10'h300, 1'b1, 1'b1, 1'b1);
        ctl(32'h0000_0050);
        chk(col_out === 1'b0, "loopback col");
        ctl(32'h0000_0070);
        transmit_active <= 1'b1;
        cyc(2);
        chk(col_out === 1'b1, "col test");
        collision_event <= 1'b0;
        transmit_active <= 1'b0;
        cyc(2);
        chk(col_out === 1'b0, "col test low");
    endtask
    task t_modes;
        int i;
        ctl(32'h0000_0042);
        chk(er_oe === 1'b0 && col_oe === 1'b1, "rgmii oe");
        seq(10'h300, 1'b1, 1'b0, 1'b0);
        ctl(32'h0000_0043);
        chk(col_oe === 1'b0, "tbi col oe");
        seq(10'h300, 1'b1, 1'b1, 1'b1);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rdat[STAT_TWO_CLOCK] === 1'b0, "one clock");
        chk(even_clk === 1'b0, "even clock idle");
        ctl(32'h0000_004B);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rdat[STAT_TWO_CLOCK] === 1'b1, "two clock");
        // Even clock is high while the receive clock is low
        for (i = 0; i < 12; i++) begin
            @(negedge pclk);
            if (even_clk === 1'b1 && rclk_w === 1'b0) break;
        end
        chk(i < 12, "even clock");
        @(posedge pclk);
        ctl(32'h0000_0044);
        chk(er_oe === 1'b0 && col_oe === 1'b0, "rtbi oe");
        seq(10'h010, 1'b1, 1'b0, 1'b0);
        seq(10'h200, 1'b0, 1'b0, 1'b0);
    endtask
    task t_fifo;
        ctl(32'h0000_0040);
        run <= 1'b0;
        cyc(4); // A link edge still in the synchroniser must not pop
        repeat (FIFO_DEPTH) push(10'h155);
        @(negedge pclk);
        chk(word_ready === 1'b0, "fifo refuses");
        @(posedge pclk);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rdat[STAT_FIFO_FULL] === 1'b1, "fifo full");
        run <= 1'b1;
        cyc(90);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rdat[STAT_FIFO_EMPTY] === 1'b1, "fifo empty");
        run <= 1'b0;
        ctl(32'h0000_0000);
        chk(rclk_oe === 1'b1, "dce clock");
        seq(10'h100, 1'b1, 1'b1, 1'b0);
        ctl(32'h0000_0040);
        chk(rclk_oe === 1'b0, "dte clock");
        run <= 1'b1;
    endtask
    // Main sequence; a second reset lands in mid-run
    initial begin
        {psel, penable, pwrite, word_valid} = 4'h0;
        {collision_event, transmit_active, strap_en} = 3'h1;
        presetn = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        word_data = 10'h000;
        run = 1'b1;
        straps = 3'h0;
        flip = 1'b0;
        n_fail = 0;
        total_checks = 0;
        do_reset(3'b010);
        t_apb;
        t_mii;
        t_modes;
        t_fifo;
        do_reset(3'b101);
        ctl(32'h0000_0043);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rdat[STAT_TWO_CLOCK] === 1'b1, "strap two clock");
        final_report;
    end
endmodule
